// ==== logic/jrb_host.v ====
// Host sequencer that reads configuration frames back over the test port
// Function
// - Shift packet stream MSB first, 191 cycles
// - Send command, length and address writes
// - Send readback command; read header not reached at 191 cycles
// - Two no-op words end the loaded stream, shifted out only at 255 cycles
// - Last packet bit goes with TMS high
// - TMS high three, low two to Shift-IR
// - Output instruction 000100, MSB leaving Shift-IR
// - TMS high two, low two to Shift-DR
// - Readback shifts for bit count minus one
// - Last readback bit taken with TMS high
// - Finish with TMS high three cycles
// - Compare bits whose mask bit is zero
// - Mask and expected aligned to first bit
// - Expected image includes pad, no commands
// - Host switches write to read itself
// - Shutdown instruction then 24 idle cycles
// - Input instruction 000101 shifted LSB first
`timescale 1ns/1ns
`default_nettype none
`include "jrb_map.vh"
module jrb_host #(
  parameter RB_BITS = 32'd4096, // Readback bit count
  parameter PAD_BITS = 32'd512, // Bits in the leading pad frame
  parameter PKT_SHIFT = `JRB_PKT_SHIFT, // Packet bits shifted with TMS low
  parameter HALF_CYC = `JRB_TCK_HALF_CYC // Clk cycles per TCK half period
) (
  input wire clk,
  input wire rst_b,
  input wire start,
  input wire [15:0] frame_len_word,
  input wire exp_bit,
  input wire mask_bit,
  input wire tdo,
  output reg tck_ff,
  output reg tms_ff,
  output reg tdi_ff,
  output reg busy_ff,
  output reg done_ff,
  output reg rb_valid_ff,
  output reg rb_bit_ff,
  output reg rb_pad_ff,
  output reg [23:0] rb_idx_ff,
  output reg mismatch_ff,
  output reg [23:0] err_cnt_ff
);
  // One-hot sequencer states
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_DONE = 3'b100;
  // Segment kinds
  localparam K_NONE = 2'd0;
  localparam K_IR = 2'd1;
  localparam K_PKT = 2'd2;
  localparam K_CAP = 2'd3;

  // Segment table: {tms, kind, len-1}
  function [26:0] seg_info;
    input [4:0] s;
    begin
      case (s)
        5'd0: seg_info = {1'b1, K_NONE, 24'd4}; // Five ones to reset
        5'd1: seg_info = {1'b0, K_NONE, 24'd0};
        5'd2: seg_info = {1'b1, K_NONE, 24'd1};
        5'd3: seg_info = {1'b0, K_NONE, 24'd1};
        5'd4: seg_info = {1'b0, K_IR, 24'd4};
        5'd5: seg_info = {1'b1, K_IR, 24'd0};
        5'd6: seg_info = {1'b1, K_NONE, 24'd0};
        5'd7: seg_info = {1'b0, K_NONE, 24'd23};
        5'd8: seg_info = {1'b1, K_NONE, 24'd1};
        5'd9: seg_info = {1'b0, K_NONE, 24'd1};
        5'd10: seg_info = {1'b0, K_IR, 24'd4};
        5'd11: seg_info = {1'b1, K_IR, 24'd0};
        5'd12: seg_info = {1'b1, K_NONE, 24'd1};
        5'd13: seg_info = {1'b0, K_NONE, 24'd1};
        5'd14: seg_info = {1'b0, K_PKT, PKT_SHIFT[23:0] - 24'd1};
        5'd15: seg_info = {1'b1, K_PKT, 24'd0};
        5'd16: seg_info = {1'b1, K_NONE, 24'd2};
        5'd17: seg_info = {1'b0, K_NONE, 24'd1};
        5'd18: seg_info = {1'b0, K_IR, 24'd4};
        5'd19: seg_info = {1'b1, K_IR, 24'd0};
        5'd20: seg_info = {1'b1, K_NONE, 24'd1};
        5'd21: seg_info = {1'b0, K_NONE, 24'd1};
        5'd22: seg_info = {1'b0, K_CAP, RB_BITS[23:0] - 24'd2};
        5'd23: seg_info = {1'b1, K_CAP, 24'd0};
        5'd24: seg_info = {1'b1, K_NONE, 24'd2};
        5'd25: seg_info = {1'b0, K_NONE, 24'd1};
        default: seg_info = {1'b1, K_NONE, 24'd2};
      endcase
    end
  endfunction

  // Instruction loaded on entry to an instruction segment
  function [6:0] ir_load;
    input [4:0] s;
    begin
      if (s == 5'd4) begin
        ir_load = {1'b1, `JRB_IR_SHUTDOWN};
      end else if (s == 5'd10) begin
        ir_load = {1'b1, `JRB_IR_CFG_IN};
      end else if (s == 5'd18) begin
        ir_load = {1'b1, `JRB_IR_CFG_OUT};
      end else begin
        ir_load = 7'h00;
      end
    end
  endfunction

  reg [2:0] state_ff; // Sequencer state
  reg [4:0] seg_ff; // Current segment
  reg [23:0] cnt_ff; // Bits left in segment minus one
  reg [7:0] ph_ff; // Phase inside one TCK period
  reg [5:0] ir_ff; // Instruction shifter, LSB out
  reg [255:0] pkt_ff; // Packet shifter, MSB out
  reg tdo_s1_ff; // Pin synchroniser, first stage
  reg tdo_s2_ff;
  reg tdo_s3_ff;
  reg tdo_ff; // Filtered pin level
  wire [26:0] cur = seg_info(seg_ff);
  wire [26:0] first_seg = seg_info(5'd0); // Entry segment, loaded at start
  wire [26:0] nxt_seg_info = seg_info(seg_ff + 5'd1);
  wire [6:0] nxt_ir = ir_load(seg_ff + 5'd1);
  wire [7:0] half = HALF_CYC[7:0];
  wire fall_ev = (ph_ff == 8'h00); // TCK goes low, outputs change
  wire rise_ev = (ph_ff == half); // TCK goes high, device samples
  // Take the agreed level in the cycle it is agreed; the registered copy lags one clk
  wire cap_bit = (tdo_s2_ff == tdo_s3_ff) ? tdo_s3_ff : tdo_ff;

  // Three-flop pin filter; a change counts once stages two and three agree
  always @(posedge clk) begin
    if (!rst_b) begin
      tdo_s1_ff <= 1'b0;
      tdo_s2_ff <= 1'b0;
      tdo_s3_ff <= 1'b0;
      tdo_ff <= 1'b0;
    end else begin
      tdo_s1_ff <= tdo;
      tdo_s2_ff <= tdo_s1_ff;
      tdo_s3_ff <= tdo_s2_ff;
      if (tdo_s2_ff == tdo_s3_ff) begin
        tdo_ff <= tdo_s3_ff;
      end
    end
  end

  // Main sequencer: TCK divider, pin drive, capture and compare
  always @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      seg_ff <= 5'd0;
      cnt_ff <= 24'h0000;
      ph_ff <= 8'h00;
      ir_ff <= 6'h00;
      pkt_ff <= 256'h0;
      tck_ff <= 1'b0;
      tms_ff <= 1'b1;
      tdi_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      rb_valid_ff <= 1'b0;
      rb_bit_ff <= 1'b0;
      rb_pad_ff <= 1'b0;
      rb_idx_ff <= 24'h0000;
      mismatch_ff <= 1'b0;
      err_cnt_ff <= 24'h0000;
    end else begin
      done_ff <= 1'b0;
      rb_valid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          tck_ff <= 1'b0;
          if (start) begin
            // Whole stream is fixed here; the write-to-read switch is ours
            pkt_ff <= {`JRB_W_DUMMY, `JRB_W_SYNC0, `JRB_W_SYNC1,
              `JRB_W_CMD_HDR, `JRB_W_CMD_PRE,
              `JRB_W_LEN_HDR, frame_len_word,
              `JRB_W_FAR_HDR, `JRB_W_ZERO, `JRB_W_ZERO,
              `JRB_W_CMD_HDR, `JRB_W_READBACK_CMD,
              `JRB_W_RD_HDR, `JRB_W_ZERO,
              `JRB_W_NOOP, `JRB_W_NOOP};
            seg_ff <= 5'd0;
            cnt_ff <= first_seg[23:0];
            ph_ff <= 8'h00;
            busy_ff <= 1'b1;
            mismatch_ff <= 1'b0;
            err_cnt_ff <= 24'h0000;
            rb_idx_ff <= 24'h0000;
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          // Free-running divider sets the TCK period
          if (ph_ff == half + half - 8'd1) begin
            ph_ff <= 8'h00;
          end else begin
            ph_ff <= ph_ff + 8'd1;
          end
          if (fall_ev) begin
            // Drive on the falling edge so TMS and TDI are stable at the rise
            tck_ff <= 1'b0;
            tms_ff <= cur[26];
            if (cur[25:24] == K_IR) begin
              tdi_ff <= ir_ff[0];
            end else if (cur[25:24] == K_PKT) begin
              tdi_ff <= pkt_ff[255];
            end else begin
              tdi_ff <= 1'b0;
            end
          end else if (rise_ev) begin
            tck_ff <= 1'b1;
            // TDO moved at the previous fall; the filter settles in time
            if (cur[25:24] == K_CAP) begin
              rb_valid_ff <= 1'b1;
              rb_bit_ff <= cap_bit;
              rb_pad_ff <= (rb_idx_ff < PAD_BITS[23:0]);
              rb_idx_ff <= rb_idx_ff + 24'd1;
              if (!mask_bit && (cap_bit != exp_bit)) begin
                mismatch_ff <= 1'b1;
                err_cnt_ff <= err_cnt_ff + 24'd1;
              end
            end
            if (cur[25:24] == K_IR) begin
              ir_ff <= {1'b0, ir_ff[5:1]};
            end
            if (cur[25:24] == K_PKT) begin
              pkt_ff <= {pkt_ff[254:0], 1'b0};
            end
            if (cnt_ff != 24'h0000) begin
              cnt_ff <= cnt_ff - 24'd1;
            end else if (seg_ff == `JRB_SEG_LAST) begin
              state_ff <= ST_DONE;
            end else begin
              seg_ff <= seg_ff + 5'd1;
              cnt_ff <= nxt_seg_info[23:0];
              if (nxt_ir[6]) begin
                ir_ff <= nxt_ir[5:0];
              end
            end
          end
        end
        ST_DONE: begin
          // Divider keeps running so the last high phase is a full half period
          if (ph_ff == half + half - 8'd1) begin
            ph_ff <= 8'h00;
          end else begin
            ph_ff <= ph_ff + 8'd1;
          end
          // Last fall at the usual phase, then go idle
          if (fall_ev) begin
            tck_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // jrb_host
`default_nettype wire

// ==== logic/jrb_map.vh ====
// Constants for the test-port configuration readback host
`ifndef JRB_MAP_VH
`define JRB_MAP_VH
// Clock and test clock timing
`define JRB_CLK_NS 40
`define JRB_TCK_HALF_NS 160
`define JRB_TCK_HALF_CYC (`JRB_TCK_HALF_NS / `JRB_CLK_NS)
// Instruction codes, six bits
`define JRB_IR_SHUTDOWN 6'h0d
`define JRB_IR_CFG_IN 6'h05
`define JRB_IR_CFG_OUT 6'h04
// Packet stream words
`define JRB_W_DUMMY 16'hffff
`define JRB_W_SYNC0 16'haa99
`define JRB_W_SYNC1 16'h5566
`define JRB_W_CMD_HDR 16'h30a1
`define JRB_W_CMD_PRE 16'h0008
`define JRB_W_LEN_HDR 16'h31a1
`define JRB_W_FAR_HDR 16'h3022
`define JRB_W_ZERO 16'h0000
`define JRB_W_READBACK_CMD 16'h0004
`define JRB_W_RD_HDR 16'h4880
`define JRB_W_NOOP 16'h2000
// Shift counts and last segment number
`define JRB_PKT_SHIFT 191
`define JRB_SHUTDOWN_IDLE 24
`define JRB_SEG_LAST 5'd26
`endif

// ==== verif/jrb_host_assertions.sv ====
// Port checks for the readback host
`timescale 1ns/1ns
`default_nettype none
module jrb_host_assertions #(parameter HALF_CYC = 32'd4) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic exp_bit,
  input wire logic mask_bit,
  input wire logic tck_ff,
  input wire logic tms_ff,
  input wire logic tdi_ff,
  input wire logic busy_ff,
  input wire logic done_ff,
  input wire logic rb_valid_ff,
  input wire logic rb_bit_ff,
  input wire logic [23:0] rb_idx_ff,
  input wire logic mismatch_ff,
  input wire logic [23:0] err_cnt_ff
);
  logic [7:0] hc_ff; // Cycles the test clock has stood high
  // Count high phase; cleared while low or in reset
  always @(posedge clk) hc_ff <= (!rst_b || !tck_ff) ? 8'h00 : hc_ff + 8'h01;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take; start && !busy_ff; endsequence
  // Compared bit that differs from the expected one
  sequence s_bad; rb_valid_ff && !$past(mask_bit) && rb_bit_ff != $past(exp_bit); endsequence
  a_tck_half: assert property ($fell(tck_ff) |-> hc_ff == HALF_CYC)
    else $error("test clock high phase has wrong length");
  a_pins_steady: assert property ($rose(tck_ff) |-> $stable(tms_ff) && $stable(tdi_ff))
    else $error("tms or tdi moved at a rising test clock");
  a_take_busy: assert property (s_take |=> busy_ff && rb_idx_ff == 0 && err_cnt_ff == 0)
    else $error("start not taken cleanly");
  a_done_ends: assert property (done_ff |=> !done_ff && !busy_ff)
    else $error("done not a single pulse at run end");
  a_idle_low: assert property (!busy_ff |-> !tck_ff)
    else $error("test clock runs while idle");
  a_valid_rise: assert property (rb_valid_ff |-> $rose(tck_ff) && rb_idx_ff == $past(rb_idx_ff) + 24'h1)
    else $error("readback capture off the rising test clock");
  a_err_flag: assert property (s_bad |-> ##[0:1] mismatch_ff)
    else $error("compared bit differed but no mismatch flag");
  a_err_step: assert property (err_cnt_ff != $past(err_cnt_ff) |-> err_cnt_ff == $past(err_cnt_ff) + 24'h1 || err_cnt_ff == 0)
    else $error("error count jumped");
endmodule // jrb_host_assertions
bind jrb_host jrb_host_assertions #(.HALF_CYC(HALF_CYC)) chk_i (.clk, .rst_b, .start, .exp_bit,
  .mask_bit, .tck_ff, .tms_ff, .tdi_ff, .busy_ff, .done_ff, .rb_valid_ff, .rb_bit_ff, .rb_idx_ff,
  .mismatch_ff, .err_cnt_ff);
`default_nettype wire

// ==== verif/jrb_dev_model.sv ====
// Behavioural device end of the test port: logs pins, returns readback bits
`timescale 1ns/1ns
`default_nettype none
module jrb_dev_model #(parameter int RB_START = 262, parameter int RB_BITS = 64) (
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo
);
  logic tms_log [0:1023]; // Pins seen at each rise
  logic tdi_log [0:1023];
  int n_rise = 0; // Rises since time zero
  int pos = 0; // Rise index within a run, set by reaching reset
  int ones = 0; // Consecutive high TMS rises
  int i;
  initial tdo = 1'b0;
  // Sample on rising test clock; five ones means the port is in reset
  always @(posedge tck) begin
    tms_log[n_rise] = tms;
    tdi_log[n_rise] = tdi;
    n_rise = n_rise + 1;
    pos = (tms && ones >= 4) ? 4 : pos + 1;
    ones = tms ? ones + 1 : 0;
  end
  // Drive on falling edge; outside readout a changing value, never the last one
  always @(negedge tck) begin
    i = pos + 1 - RB_START;
    if (i >= 0 && i < RB_BITS) tdo = i[0] ^ i[2];
    else tdo = ~tdo;
  end
endmodule // jrb_dev_model
`default_nettype wire

// ==== verif/jrb_host_tb_top.sv ====
// Testbench for the readback host against the device model
`timescale 1ns/1ns
`default_nettype none
`include "jrb_map.vh"
module jrb_host_tb_top;
  localparam int RB = 64; // Short readback keeps runs brief
  localparam int PAD = 16;
  localparam int PKT = 255; // Whole stream, so read header and no-ops go out too
  logic clk = 0, rst_b = 0, start = 0, exp_bit = 0, mask_bit = 0;
  logic [15:0] flw = 16'h0000;
  logic [5:0] ir_in = `JRB_IR_CFG_IN, ir_out = `JRB_IR_CFG_OUT, ir_sd = `JRB_IR_SHUTDOWN;
  wire logic tdo, tck, tms, tdi, busy, done, rbv, rbb, rbp, mis;
  wire logic [23:0] idx, errs;
  int n_mismatch = 0, cmp_count = 0, flip = 0, skip = 0, n_rb = 0, n_pad = 0, n_done = 0;
  int segs [17] = '{5, 1, 2, 7, 2, 24, 2, 7, 3, PKT + 2, 4, 7, 3, RB + 1, 4, 2, 3}; // From 1
  logic [15:0] words [16];
  jrb_host #(.RB_BITS(RB), .PAD_BITS(PAD), .PKT_SHIFT(PKT), .HALF_CYC(4)) uut (.clk(clk),
    .rst_b(rst_b), .start(start), .frame_len_word(flw), .exp_bit(exp_bit), .mask_bit(mask_bit),
    .tdo(tdo), .tck_ff(tck), .tms_ff(tms), .tdi_ff(tdi), .busy_ff(busy), .done_ff(done),
    .rb_valid_ff(rbv), .rb_bit_ff(rbb), .rb_pad_ff(rbp), .rb_idx_ff(idx), .mismatch_ff(mis),
    .err_cnt_ff(errs));
  jrb_dev_model #(.RB_START(71 + PKT), .RB_BITS(RB)) dev (.tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo));
  initial forever #20 clk = ~clk;
  // Expected image plus mask; one flipped bit compared, one flipped bit masked
  always @(posedge clk) begin
    #1 exp_bit = (idx[0] ^ idx[2]) ^ (idx == flip || idx == skip);
    mask_bit = (idx == skip);
  end
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Every captured bit must be the one the device sent
  always @(posedge clk) begin
    #2;
    if (done === 1'b1) n_done++;
    if (rbv === 1'b1) begin
      chk(rbb === (n_rb[0] ^ n_rb[2]), "readback bit");
      if (rbp === 1'b1) n_pad++;
      n_rb++;
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One whole run, then the wire record is judged
  task automatic run(input logic [15:0] w, input int f, input int s, input logic refuse,
      input int ex);
    int b, i, k, v;
    b = dev.n_rise;
    flw = w;
    flip = f;
    skip = s;
    n_rb = 0;
    n_pad = 0;
    n_done = 0;
    i = 0;
    words = '{`JRB_W_DUMMY, `JRB_W_SYNC0, `JRB_W_SYNC1, `JRB_W_CMD_HDR, `JRB_W_CMD_PRE,
      `JRB_W_LEN_HDR, w, `JRB_W_FAR_HDR, `JRB_W_ZERO, `JRB_W_ZERO, `JRB_W_CMD_HDR, `JRB_W_READBACK_CMD,
      `JRB_W_RD_HDR, `JRB_W_ZERO, `JRB_W_NOOP, `JRB_W_NOOP};
    @(posedge clk);
    #1 start = 1;
    @(posedge clk);
    #1 start = 0;
    // Starts given while busy must be ignored
    do begin
      @(posedge clk);
      #1 start = refuse & busy;
      i++;
    end while (busy !== 1'b0 && i < 50000);
    @(posedge clk); // Let the done pulse be counted
    k = b;
    for (i = 0; i < 17; i++) begin
      for (v = 0; v < segs[i]; v++) begin
        chk(dev.tms_log[k] === ~i[0], "tms sequence");
        k++;
      end
    end
    chk(dev.n_rise == k, "test clock count");
    chk(n_done == 1, "done pulse count");
    for (i = 0; i < 6; i++) begin
      chk(dev.tdi_log[b + 10 + i] === ir_sd[i], "shutdown instruction");
      chk(dev.tdi_log[b + 45 + i] === ir_in[i], "input instruction");
      chk(dev.tdi_log[b + 61 + PKT + i] === ir_out[i], "output instruction");
    end
    for (i = 0; i < PKT + 1; i++) begin
      chk(dev.tdi_log[b + 55 + i] === words[i / 16][15 - i % 16], "packet");
    end
    chk(n_rb == RB && n_pad == PAD, "readback and pad counts");
    chk(errs === 24'(ex) && mis === (ex != 0), "error count");
  endtask
  task automatic t_masked_flip(); run(16'h1234, 5, 40, 1'b0, 1); endtask
  task automatic t_refused_start(); run(16'h00c3, 200, 201, 1'b1, 0); endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_b = 1;
    t_masked_flip();
    t_refused_start();
    end_of_test();
  end
  // Two runs take about 6500 cycles
  initial begin
    #(40 * 20000);
    n_mismatch++;
    end_of_test();
  end
endmodule // jrb_host_tb_top
`default_nettype wire
